/* common/arc_pkg.sv */
/*
 package for the analog reference conditioner: codes, scales, thresholds and timing.
 assumes samples are unsigned 16-bit codes of full scale (10 V or 20 mA).
*/
package arc_pkg;
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned SAMPLE_W        = 16;
    localparam int unsigned REF_W           = 16;
    localparam int unsigned PCT_W           = 16;
    localparam int unsigned FULL_SCALE      = 65535;
    localparam int unsigned PCT_FULL        = 10000;
    // loss thresholds as fractions of full scale: 1 V of 10 V, 2 mA of 20 mA
    localparam int unsigned LOSS_V_NUM      = 1;
    localparam int unsigned LOSS_V_DEN      = 10;
    localparam int unsigned LOSS_I_NUM      = 2;
    localparam int unsigned LOSS_I_DEN      = 20;
    localparam logic [SAMPLE_W-1:0] LOSS_V_LEVEL =
        SAMPLE_W'(FULL_SCALE * LOSS_V_NUM / LOSS_V_DEN);
    localparam logic [SAMPLE_W-1:0] LOSS_I_LEVEL =
        SAMPLE_W'(FULL_SCALE * LOSS_I_NUM / LOSS_I_DEN);
    // repetition frequency ceiling
    localparam int unsigned RPT_FMAX_KHZ    = 150;
    localparam int unsigned RPT_MIN_HALF    =
        (CLK_HZ + 2 * RPT_FMAX_KHZ * 1000 - 1) / (2 * RPT_FMAX_KHZ * 1000);
    localparam int unsigned TC_MS_MAX       = 5000;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam int unsigned TC_CODE_W       = 13;
    localparam int unsigned SHIFT_W         = 5;

    typedef enum logic [1:0] {
        ARC_MON_OFF,
        ARC_MON_WARN,
        ARC_MON_STOP,
        ARC_MON_TRIP
    } arc_mon_t;

    typedef enum logic [1:0] {
        ARC_MFO_OFF,
        ARC_MFO_DIGITAL,
        ARC_MFO_ANALOG,
        ARC_MFO_REPFREQ
    } arc_mfo_t;

    localparam logic [1:0] STOP_COAST = 2'h0;
    localparam logic [1:0] STOP_DECEL = 2'h2;
endpackage

/* hdl/arc_conditioner.sv */
/*
 analog reference conditioner: fifo, low-pass, tolerance band with hysteresis,
 two-point characteristic, signal-loss monitor and multifunction output selector.
 assumes samples arrive as valid/ready words on core_clk from the converter.
*/
`timescale 1ns/1ps
// Overview of operation
// - tolerance band widens zero crossing
// - hold positive minimum until below negative edge
// - minimum value turns band into hysteresis
// - low-pass averaging, thirteen time constants
// - code zero passes value unfiltered
// - nonzero codes equal milliseconds of constant
// - mode 0 none, mode 1 warning below threshold
// - mode 2 warn, decelerate, error after hold
// - mode 3 warning, fault and coast stop
// - monitor regardless of drive release
// - output mode 0 low, 1/2/3 digital analog freq
// - unselected output functions deactivated internally
// - two-point linear input to output mapping
module arc_conditioner
    import arc_pkg::*;
#(
    parameter int unsigned SAMPLE_HZ  = 1000,
    parameter int unsigned HOLD_TICKS = 200_000_000
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [SAMPLE_W-1:0]     sample_data,
    input  wire logic                    sample_valid,
    output logic                         sample_ready,
    input  wire logic                    current_input,
    input  wire logic [TC_CODE_W-1:0]    filter_tc_code,
    input  wire logic [PCT_W-1:0]        tolerance_band,
    input  wire logic [REF_W-1:0]        minimum_value,
    input  wire logic [PCT_W-1:0]        first_point_input_coordinate,
    input  wire logic signed [REF_W-1:0] first_point_output,
    input  wire logic [PCT_W-1:0]        second_point_input,
    input  wire logic signed [REF_W-1:0] second_point_output,
    input  wire arc_mon_t                monitor_mode,
    input  wire logic                    drive_released,
    input  wire arc_mfo_t                output_mode,
    input  wire logic                    digital_level,
    input  wire logic                    analog_pwm,
    input  wire logic [15:0]             repfreq_half_period,
    output logic signed [REF_W-1:0]      reference_out,
    output logic                         reference_valid,
    output logic                         loss_warning,
    output logic                         loss_fault,
    output logic                         loss_error,
    output logic                         stop_request,
    output logic [1:0]                   stop_behaviour,
    output logic                         multifunction_output
);
    logic [SAMPLE_W-1:0] fifo_data;
    logic                fifo_valid;
    logic [SAMPLE_W-1:0] filt_data;
    logic                filt_valid;
    logic                bypass;
    logic [4:0]          shift;
    logic                prev_positive;
    logic signed [REF_W-1:0] next_ref;
    logic                loss_now;
    logic [31:0]         hold_cnt;
    logic                stop_latched;
    logic [15:0]         rpt_cnt;
    logic                rpt_level;

    // converts a percent (0.01 % units) to a sample code
    function automatic logic [SAMPLE_W-1:0] pct_to_code(input logic [PCT_W-1:0] p);
        logic [31:0] prod;
        prod = 32'(p) * 32'(FULL_SCALE) / 32'(PCT_FULL);
        return prod[SAMPLE_W-1:0];
    endfunction

    // time constant code to shift: 2**k ~ tau * sample rate
    function automatic logic [4:0] tc_shift(input logic [TC_CODE_W-1:0] ms);
        logic [31:0] ticks;
        logic [4:0]  k;
        ticks = 32'(ms) * 32'(SAMPLE_HZ) / 32'd1000;
        k     = 5'h0;
        for (int i = 1; i < 31; i++) begin
            if (ticks >= (32'h1 << i)) begin
                k = 5'(i);
            end
        end
        return k;
    endfunction

    arc_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (1'b1)
    );

    // codes above the top setting are clamped to it
    assign bypass = (filter_tc_code == '0);
    assign shift  = tc_shift((filter_tc_code > TC_CODE_W'(TC_MS_MAX)) ?
                             TC_CODE_W'(TC_MS_MAX) : filter_tc_code);

    arc_lowpass #(
        .WIDTH (SAMPLE_W),
        .FRAC  (16)
    ) u_lowpass (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .bypass    (bypass),
        .shift     (shift),
        .in_data   (fifo_data),
        .in_valid  (fifo_valid),
        .out_data  (filt_data),
        .out_valid (filt_valid)
    );

    // two-point characteristic, then band and hysteresis around zero
    always_comb begin
        logic signed [47:0] dy;
        logic signed [47:0] dx;
        logic signed [47:0] xx;
        logic signed [47:0] y;
        logic signed [47:0] tol;
        logic signed [47:0] minv;
        dy   = 48'(second_point_output) - 48'(first_point_output);
        dx   = 48'(signed'({1'b0, pct_to_code(second_point_input)})) -
               48'(signed'({1'b0, pct_to_code(first_point_input_coordinate)}));
        xx   = 48'(signed'({1'b0, filt_data})) -
               48'(signed'({1'b0, pct_to_code(first_point_input_coordinate)}));
        y    = (dx == 0) ? 48'(first_point_output) :
               (dy * xx) / dx + 48'(first_point_output);
        tol  = 48'(signed'({1'b0, pct_to_code(tolerance_band)}));
        minv = 48'(signed'({1'b0, minimum_value}));
        // output is shifted toward zero by the band on each side
        if (y > tol) begin
            y = y - tol;
        end else if (y < -tol) begin
            y = y + tol;
        end else begin
            y = 48'sh0;
        end
        if (prev_positive && y <= 0 && !(y < 0)) begin
            y = minv;
        end else if (!prev_positive && y >= 0 && !(y > 0)) begin
            y = -minv;
        end else if (y > 0 && y < minv) begin
            y = minv;
        end else if (y < 0 && y > -minv) begin
            y = -minv;
        end
        if (y > 48'sd32767) begin
            y = 48'sd32767;
        end else if (y < -48'sd32768) begin
            y = -48'sd32768;
        end
        next_ref = y[REF_W-1:0];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reference_out   <= '0;
            reference_valid <= 1'b0;
            prev_positive   <= 1'b1;
        end else begin
            reference_valid <= filt_valid;
            if (filt_valid) begin
                reference_out <= next_ref;
                prev_positive <= (next_ref >= 0);
            end
        end
    end

    // loss check on the raw sample; drive release deliberately not consulted
    assign loss_now = fifo_valid && (fifo_data < (current_input ? LOSS_I_LEVEL :
                                                  LOSS_V_LEVEL));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            loss_warning <= 1'b0;
            loss_fault   <= 1'b0;
        end else if (monitor_mode == ARC_MON_OFF) begin
            // no check in mode 0, so no stale flag may survive the switch
            loss_warning <= 1'b0;
            loss_fault   <= 1'b0;
        end else if (fifo_valid) begin
            loss_warning <= loss_now && (monitor_mode != ARC_MON_OFF);
            loss_fault   <= loss_now && (monitor_mode == ARC_MON_TRIP);
        end
    end

    // stop stays latched; released only by reset or by switching monitor_mode to mode 0 or 1
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stop_latched   <= 1'b0;
            stop_request   <= 1'b0;
            stop_behaviour <= STOP_DECEL;
            hold_cnt       <= '0;
            loss_error     <= 1'b0;
        end else begin
            if (monitor_mode == ARC_MON_OFF || monitor_mode == ARC_MON_WARN) begin
                stop_latched <= 1'b0;
                stop_request <= 1'b0;
                hold_cnt     <= '0;
                loss_error   <= 1'b0;
            end else if (loss_now || stop_latched) begin
                stop_latched   <= 1'b1;
                stop_request   <= 1'b1;
                stop_behaviour <= (monitor_mode == ARC_MON_TRIP) ? STOP_COAST :
                                  STOP_DECEL;
                if (monitor_mode == ARC_MON_STOP) begin
                    if (hold_cnt >= HOLD_TICKS - 1) begin
                        loss_error <= 1'b1;
                    end else begin
                        hold_cnt <= hold_cnt + 32'h1;
                    end
                end
            end
        end
    end

    // repetition frequency toggle, half period floored to the ceiling rate
    always_ff @(posedge core_clk) begin
        if (!rst_n || output_mode != ARC_MFO_REPFREQ) begin
            rpt_cnt   <= '0;
            rpt_level <= 1'b0;
        end else if (rpt_cnt + 16'h1 >= ((repfreq_half_period < 16'(RPT_MIN_HALF)) ?
                                       16'(RPT_MIN_HALF) : repfreq_half_period)) begin
            rpt_cnt   <= '0;
            rpt_level <= !rpt_level;
        end else begin
            rpt_cnt <= rpt_cnt + 16'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            multifunction_output <= 1'b0;
        end else begin
            unique case (output_mode)
                ARC_MFO_OFF:     multifunction_output <= 1'b0;
                ARC_MFO_DIGITAL: multifunction_output <= digital_level;
                ARC_MFO_ANALOG:  multifunction_output <= analog_pwm;
                ARC_MFO_REPFREQ: multifunction_output <= rpt_level;
            endcase
        end
    end

    sequence s_loss_seen;
        loss_now && monitor_mode == ARC_MON_TRIP;
    endsequence

    a_mon_off_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        monitor_mode == ARC_MON_OFF |=> !loss_warning)
        else $error("warning raised with monitor off");
    a_warn_no_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
        monitor_mode == ARC_MON_WARN |=> !stop_request)
        else $error("warning mode requested stop");
    a_trip_coast: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_loss_seen |=> loss_fault && loss_warning && stop_behaviour == STOP_COAST)
        else $error("trip mode did not coast");
    a_stop_decel: assert property (@(posedge core_clk) disable iff (!rst_n)
        loss_now && monitor_mode == ARC_MON_STOP |=>
        stop_request && stop_behaviour == STOP_DECEL)
        else $error("stop mode did not decelerate");
    a_release_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        loss_now && monitor_mode != ARC_MON_OFF && !drive_released |=> loss_warning)
        else $error("monitor gated by release");
    a_mfo_off_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        output_mode == ARC_MFO_OFF |=> !multifunction_output)
        else $error("output not low in off mode");
    a_mfo_digital: assert property (@(posedge core_clk) disable iff (!rst_n)
        output_mode == ARC_MFO_DIGITAL |=> multifunction_output == $past(digital_level))
        else $error("digital output not selected");
    a_ref_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        filt_valid |=> reference_valid)
        else $error("reference not updated");
endmodule

/* hdl/arc_fifo.sv */
/*
 synchronous fifo with valid/ready on both sides; read data from a register.
 assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module arc_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    logic             stored;

    // out register counts as one slot beyond the memory
    assign stored   = (count != '0);
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = stored && (!out_valid || out_ready);

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge core_clk) disable iff (!rst_n)
        count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule

/* hdl/arc_lowpass.sv */
/*
 first-order recursive average, one update per accepted sample.
 assumes shift is chosen so that 2**shift approximates tau / sample period.
*/
`timescale 1ns/1ps
module arc_lowpass #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned FRAC  = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             bypass,
    input  wire logic [4:0]       shift,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid
);
    localparam int unsigned AW = WIDTH + FRAC;
    logic [AW-1:0] acc;
    logic [AW-1:0] target;
    logic [AW:0]   next_acc;

    assign target = {in_data, {FRAC{1'b0}}};

    // y += (x - y) >> k ; arithmetic kept one bit wider for the sign
    always_comb begin
        next_acc = {1'b0, acc} + ((({1'b0, target}) - ({1'b0, acc})) >>> shift);
        if (target < acc) begin
            next_acc = {1'b0, acc} - ((({1'b0, acc}) - ({1'b0, target})) >> shift);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc       <= '0;
            out_data  <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                if (bypass) begin
                    acc      <= target;
                    out_data <= in_data;
                end else begin
                    acc      <= next_acc[AW-1:0];
                    out_data <= next_acc[AW-1:FRAC];
                end
            end
        end
    end

    a_bypass_passes: assert property (@(posedge core_clk) disable iff (!rst_n)
        in_valid && bypass |=> out_valid && out_data == $past(in_data))
        else $error("bypass did not forward sample");
endmodule

/* verif/arc_adc_model.sv */
/*
 converter front-end model: offers reference samples on valid/ready.
 assumes the conditioner samples valid and ready on the rising edge of core_clk.
*/
`timescale 1ns/1ps
module arc_adc_model (
    input  wire logic        core_clk,
    input  wire logic        sample_ready,
    output logic [15:0]      sample_data,
    output logic             sample_valid
);
    initial begin
        sample_data  = 16'h0000;
        sample_valid = 1'b0;
    end

    // gap models a slow converter; word held until ready is seen at an edge
    task automatic put(input logic [15:0] v, input int gap);
        repeat (gap + 1) @(posedge core_clk);
        sample_valid <= 1'b1;
        sample_data  <= v;
        do @(posedge core_clk); while (sample_ready !== 1'b1);
        sample_valid <= 1'b0;
        // released bus shows the inverse so stale data never looks valid
        sample_data  <= ~v;
    endtask
endmodule

/* verif/arc_conditioner_tb.sv */
/*
 bench for arc_conditioner: fifo burst pass-through, output selector, band, filter, monitor.
 assumes 200 MHz core_clk, synchronous active-low reset and the converter model.
*/
`timescale 1ns/1ps
module arc_conditioner_tb;
    import arc_pkg::*;
    logic               core_clk = 1'b0;
    logic               rst_n    = 1'b0;
    logic [15:0]        sample_data;
    logic               sample_valid, sample_ready;
    logic               cur = 1'b0, rel = 1'b0, dig = 1'b0, apwm = 1'b0;
    logic [12:0]        tc   = 13'h0000;
    logic [15:0]        band = 16'h0000, minv = 16'h0000, x1 = 16'h0000, x2 = 16'h2710;
    logic signed [15:0] y1   = 16'h0000, y2 = 16'h2710, ref_out;
    arc_mon_t           mon  = ARC_MON_OFF;
    arc_mfo_t           omode = ARC_MFO_OFF;
    logic [15:0]        half = 16'h000a;
    logic               ref_v, warn, fault, err, stop, mfo;
    logic [1:0]         sb;
    int                 err_count = 0;
    int                 n_tests = 0;

    always #2.5 core_clk = ~core_clk;

    arc_adc_model u_arc_adc_model (.core_clk(core_clk), .sample_ready(sample_ready),
        .sample_data(sample_data), .sample_valid(sample_valid));

    arc_conditioner #(.HOLD_TICKS(20)) u_arc_conditioner (
        .core_clk(core_clk), .rst_n(rst_n), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .current_input(cur),
        .filter_tc_code(tc), .tolerance_band(band), .minimum_value(minv),
        .first_point_input_coordinate(x1), .first_point_output(y1),
        .second_point_input(x2), .second_point_output(y2), .monitor_mode(mon),
        .drive_released(rel), .output_mode(omode), .digital_level(dig), .analog_pwm(apwm),
        .repfreq_half_period(half), .reference_out(ref_out), .reference_valid(ref_v),
        .loss_warning(warn), .loss_fault(fault), .loss_error(err), .stop_request(stop),
        .stop_behaviour(sb), .multifunction_output(mfo));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge core_clk) rst_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask

    task automatic cfg(input logic [15:0] a, input logic [15:0] b, input logic [15:0] w,
                       input logic [15:0] m, input logic [12:0] t);
        @(posedge core_clk);
        y1   <= a;
        y2   <= b;
        band <= w;
        minv <= m;
        tc   <= t;
    endtask

    // one sample through the chain; result taken in the cycle its valid stands
    task automatic xfer(input logic [15:0] v, input int gap, output logic signed [15:0] r);
        int n;
        n = 0;
        u_arc_adc_model.put(v, gap);
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (ref_v !== 1'b1 && n < 40);
        if (ref_v !== 1'b1) check(16'h0000, 16'h0001);
        r = ref_out;
    endtask

    // burst through the whole chain; the drain never stalls, so ready must hold
    task automatic test_fifo();
        int got;
        got = 0;
        fork
            for (int k = 0; k < 6; k++) u_arc_adc_model.put(16'hffff, 0);
            repeat (30) begin
                @(posedge core_clk);
                #1;
                check({15'h0000, sample_ready}, 16'h0001);
                if (ref_v === 1'b1) begin
                    check(ref_out, 16'h2710);
                    got++;
                end
            end
        join
        check(16'(got), 16'h0006);
    endtask

    task automatic test_mfo();
        logic [4:0] tab [5] = '{5'h0f, 5'h0a, 5'h04, 5'h13, 5'h14};
        logic       p;
        int         n;
        foreach (tab[i]) begin
            @(posedge core_clk);
            omode <= arc_mfo_t'(tab[i][4:3]);
            dig   <= tab[i][2];
            apwm  <= tab[i][1];
            repeat (3) @(posedge core_clk);
            #1;
            check({15'h0000, mfo}, {15'h0000, tab[i][0]});
        end
        @(posedge core_clk) omode <= ARC_MFO_REPFREQ;
        for (int j = 0; j < 2; j++) begin
            p = mfo;
            n = 0;
            while (mfo === p && n < 3000) begin
                @(posedge core_clk);
                #1;
                n++;
            end
        end
        check(16'(n >= 667 && n < 3000), 16'h0001);
        @(posedge core_clk) omode <= ARC_MFO_OFF;
    endtask

    task automatic run_tab(input logic [15:0] s [5], input logic [15:0] e [5]);
        logic signed [15:0] r;
        foreach (s[i]) begin
            xfer(s[i], i, r);
            check(r, e[i]);
        end
    endtask

    task automatic test_filter();
        int                 codes [14] = '{2, 4, 8, 16, 32, 64, 128, 256, 512,
                                           1000, 2000, 3000, 4000, 5000};
        logic signed [15:0] o1, o2;
        logic signed [15:0] prev;
        prev = 16'sh7fff;
        foreach (codes[i]) begin
            cfg(16'h0000, 16'h2710, 16'h0000, 16'h0000, 13'(codes[i]));
            do_reset();
            xfer(16'hffff, 0, o1);
            xfer(16'hffff, 0, o2);
            check(16'(o1 > 0 && o1 < 10000 && o2 > o1), 16'h0001);
            check(16'(o1 <= prev), 16'h0001);
            prev = o1;
        end
    endtask

    task automatic test_loss();
        logic signed [15:0] r;
        cfg(16'h0000, 16'h2710, 16'h0000, 16'h0000, 13'h0000);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) mon <= ARC_MON_OFF;
            xfer(16'hffff, 0, r);
            mon <= arc_mon_t'(i);
            rel <= 1'(i);
            cur <= i[1];
            xfer(16'h1998, 2, r);
            check({11'h000, warn, fault, stop, sb},
                  {11'h000, 1'(i != 0), 1'(i == 3), 1'(i >= 2), (i == 3) ? 2'h0 : 2'h2});
            check({15'h0000, err}, 16'h0000);
            repeat (25) @(posedge core_clk);
            #1;
            check({15'h0000, err}, {15'h0000, 1'(i == 2)});
            xfer(16'h1999, 1, r);
            if (i == 1) check({15'h0000, warn}, 16'h0000);
        end
        @(posedge core_clk) mon <= ARC_MON_OFF;
    endtask

    initial begin
        #200_000;
        err_count++;
        report_and_stop();
    end

    initial begin
        do_reset();
        check({10'h000, ref_v, warn, fault, err, stop, mfo}, 16'h0000);
        check({14'h0000, sb}, 16'h0002);
        test_fifo();
        test_mfo();
        cfg(16'h0000, 16'h2710, 16'h0000, 16'h0000, 13'h0000);
        run_tab('{16'hffff, 16'h3333, 16'hcccc, 16'h0000, 16'h6666},
                '{16'h2710, 16'h07d0, 16'h1f40, 16'h0000, 16'h0fa0});
        // approach from positive, cross inside the band, then from negative
        cfg(16'hd8f0, 16'h2710, 16'h01f4, 16'h01f4, 13'h0000);
        run_tab('{16'hffff, 16'h8000, 16'h7ae1, 16'h0000, 16'h8000},
                '{16'h1a44, 16'h01f4, 16'h01f4, 16'he5bc, 16'hfe0c});
        test_filter();
        test_loss();
        report_and_stop();
    end
endmodule
